// ==== core/efa_eeprom_ctrl.sv ====
// EEPROM and expansion flash access control with AXI4-Lite registers
// What this block does
// - Multiple-access plus read command reloads every EEPROM-backed CSR from EEPROM.
// - Multiple-access bit stays set during reload, then self-clears.
// - Multiple-access with write command is an error; no multi-word write happens.
// - Multiple-access bit resets to one, so reload runs after any reset.
// - Single-access with read command reads addressed dword into data register.
// - Single-access with write command writes data register to addressed dword.
// - Single-access bit stays set until the access completes, then self-clears.
// - Bits 12:8 hold the dword offset for single accesses; reset zero.
// - Dword n is words 2n and 2n+1; both words are accessed.
// - Read-only bit 20 shows one for flash, zero for ROM.
// - Memory writes reach the flash only while bit 21 is set.
// - Bits 19:16 are a read/write ROM timing field, reset zero.
// - Reload sums the data read and compares with stored checksum.
// - Checksum mismatch on reload sets control register bit 4.
// - Read-only bit 0 reads one when an EEPROM is attached.
// - Read command bit 1 resets to one; reads need multi or single bit.
// - Write command bit 2 resets to zero; writes need the single bit.
//
// The AXI4-Lite slave port and the address map are this design's own decisions.
`timescale 1ns/1ps
module efa_eeprom_ctrl (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write channels
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // AXI4-Lite read channels
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Chip status and soft reset
    input wire logic soft_reset,
    input wire logic nv_device_present,
    input wire logic flash_attached,
    // EEPROM word port
    output logic word_req,
    output logic word_we,
    output logic [5:0] word_addr,
    output logic [15:0] word_wdata,
    input wire logic word_ack,
    input wire logic [15:0] word_rdata,
    // Reloaded CSR image to the rest of the chip
    input wire logic [3:0] csr_img_index,
    output logic [31:0] csr_img_value,
    // Expansion ROM write gating
    input wire logic rom_wr_req,
    output logic flash_wr_strobe,
    output logic [3:0] rom_timing
);

    // AXI slave state
    logic aw_full_r, w_full_r, bvalid_r, rvalid_r;
    logic [7:0] aw_addr_r;
    logic [31:0] w_data_r, rdata_r;
    logic [3:0] w_strb_r;
    logic [1:0] bresp_r, rresp_r;

    // Control state and sequencer results
    logic rd_sel_r, wr_sel_r, multi_r, single_r, sum_err_r, cmd_err_r, gate_r, kick_r, seq_done;
    logic [4:0] addr_r, idx_r;
    logic [3:0] timing_r;
    logic [31:0] data_r, sum_r, seq_rdata;
    efa_pkg::efa_state_e state_r;

    // Bus decode
    assign awready = !aw_full_r;
    assign wready = !w_full_r;
    assign arready = !rvalid_r;
    assign bvalid = bvalid_r;
    assign bresp = bresp_r;
    assign rvalid = rvalid_r;
    assign rdata = rdata_r;
    assign rresp = rresp_r;

    wire wr_fire = aw_full_r && w_full_r && !bvalid_r;
    wire rd_fire = arvalid && !rvalid_r;
    wire wr_ctrl = wr_fire && aw_addr_r[7:2] == efa_pkg::CTRL_OFF[7:2];
    wire wr_data = wr_fire && aw_addr_r[7:2] == efa_pkg::DATA_OFF[7:2];
    wire wr_stat = wr_fire && aw_addr_r[7:2] == efa_pkg::STAT_OFF[7:2];
    wire wr_hit = wr_ctrl || wr_data || wr_stat;
    wire rd_ctrl = araddr[7:2] == efa_pkg::CTRL_OFF[7:2];
    wire rd_data = araddr[7:2] == efa_pkg::DATA_OFF[7:2];
    wire rd_stat = araddr[7:2] == efa_pkg::STAT_OFF[7:2];
    wire rd_hit = rd_ctrl || rd_data || rd_stat;
    wire [31:0] wmask = {{8{w_strb_r[3]}}, {8{w_strb_r[2]}}, {8{w_strb_r[1]}}, {8{w_strb_r[0]}}};

    // Register read views, reserved bits tied to zero
    wire [31:0] ctrl_rd = {10'h000, gate_r, flash_attached, timing_r, 3'h0, addr_r, 1'b0,
        single_r, multi_r, sum_err_r, 1'b0, wr_sel_r, rd_sel_r, nv_device_present};
    wire [31:0] stat_rd = {31'h0000_0000, cmd_err_r};
    wire [31:0] rd_mux = rd_ctrl ? ctrl_rd : (rd_data ? data_r : (rd_stat ? stat_rd : 32'h0));
    wire [31:0] ctrl_wv = (ctrl_rd & ~wmask) | (w_data_r & wmask);
    wire [31:0] data_wv = (data_r & ~wmask) | (w_data_r & wmask);
    wire [31:0] stat_wv = w_data_r & wmask;

    // Command decode
    wire cmd_lock = multi_r || single_r;
    wire cmd_wr = wr_ctrl && !cmd_lock;
    wire c_rd = ctrl_wv[efa_pkg::RD_BIT];
    wire c_wr = ctrl_wv[efa_pkg::WR_BIT];
    wire c_multi = ctrl_wv[efa_pkg::MULTI_BIT];
    wire c_single = ctrl_wv[efa_pkg::SINGLE_BIT];
    wire good_multi = c_rd && !c_wr && !c_single;
    wire good_single = (c_rd ^ c_wr) && !c_multi;
    wire cmd_bad = cmd_wr && ((c_multi && !good_multi) || (c_single && !good_single));
    wire multi_set = cmd_wr && c_multi && good_multi;
    wire single_set = cmd_wr && c_single && good_single;

    // Sequencing
    wire idle = (state_r == efa_pkg::ST_IDLE);
    wire reload_start = idle && multi_r && nv_device_present;
    wire single_start = idle && !multi_r && single_r && nv_device_present;
    wire reload_done = (state_r == efa_pkg::ST_RELOAD) && seq_done;
    wire last_dword = (idx_r == efa_pkg::SUM_IDX);
    wire chk_end = reload_done && last_dword;
    wire chk_fail = chk_end && (seq_rdata != sum_r);
    wire img_we = reload_done && !last_dword;
    wire single_done = (state_r == efa_pkg::ST_SINGLE) && seq_done;
    wire multi_clr = chk_end || (idle && multi_r && !nv_device_present);
    wire single_clr = single_done || (idle && !multi_r && single_r && !nv_device_present);
    wire multi_nxt = soft_reset || multi_set || (multi_r && !multi_clr);
    wire single_nxt = single_set || (single_r && !single_clr);
    wire sum_err_nxt = chk_fail || (sum_err_r && !reload_start);
    wire cmd_err_nxt = cmd_bad || (cmd_err_r && !(wr_stat && stat_wv[efa_pkg::CMDERR_BIT]));
    wire seq_write = (state_r == efa_pkg::ST_SINGLE) && wr_sel_r;
    wire [4:0] seq_off = (state_r == efa_pkg::ST_RELOAD) ? idx_r : addr_r;

    assign flash_wr_strobe = rom_wr_req && gate_r && flash_attached;
    assign rom_timing = timing_r;

    // AXI write channel capture and response
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_full_r <= 1'b0;
            aw_addr_r <= 8'h00;
            w_full_r <= 1'b0;
            w_data_r <= 32'h0000_0000;
            w_strb_r <= 4'h0;
            bvalid_r <= 1'b0;
            bresp_r <= efa_pkg::RESP_OKAY;
        end
        else
        begin
            if (awvalid && !aw_full_r)
            begin
                aw_full_r <= 1'b1;
                aw_addr_r <= awaddr;
            end
            if (wvalid && !w_full_r)
            begin
                w_full_r <= 1'b1;
                w_data_r <= wdata;
                w_strb_r <= wstrb;
            end
            if (wr_fire)
            begin
                aw_full_r <= 1'b0;
                w_full_r <= 1'b0;
                bvalid_r <= 1'b1;
                bresp_r <= wr_hit ? efa_pkg::RESP_OKAY : efa_pkg::RESP_SLVERR;
            end
            else if (bvalid_r && bready)
                bvalid_r <= 1'b0;
        end
    end

    // AXI read channel
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= efa_pkg::RESP_OKAY;
        end
        else if (rd_fire)
        begin
            rvalid_r <= 1'b1;
            rdata_r <= rd_mux;
            rresp_r <= rd_hit ? efa_pkg::RESP_OKAY : efa_pkg::RESP_SLVERR;
        end
        else if (rvalid_r && rready)
            rvalid_r <= 1'b0;
    end

    // Control register fields
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rd_sel_r <= efa_pkg::RD_RST;
            wr_sel_r <= efa_pkg::WR_RST;
            multi_r <= efa_pkg::MULTI_RST;
            single_r <= efa_pkg::SINGLE_RST;
            addr_r <= efa_pkg::ADDR_RST;
            timing_r <= efa_pkg::TIM_RST;
            gate_r <= efa_pkg::GATE_RST;
            sum_err_r <= 1'b0;
            cmd_err_r <= 1'b0;
        end
        else
        begin
            multi_r <= multi_nxt;
            single_r <= single_nxt;
            sum_err_r <= sum_err_nxt;
            cmd_err_r <= cmd_err_nxt;
            if (soft_reset)
            begin
                rd_sel_r <= efa_pkg::RD_RST;
                wr_sel_r <= efa_pkg::WR_RST;
            end
            else if (cmd_wr)
            begin
                rd_sel_r <= c_rd;
                wr_sel_r <= c_wr;
                addr_r <= ctrl_wv[efa_pkg::ADDR_HI:efa_pkg::ADDR_LO];
            end
            if (wr_ctrl)
            begin
                timing_r <= ctrl_wv[efa_pkg::TIM_HI:efa_pkg::TIM_LO];
                gate_r <= ctrl_wv[efa_pkg::GATE_BIT];
            end
        end
    end

    // Data register: software writes, single reads fill it
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            data_r <= efa_pkg::DATA_RST;
        else if (single_done && !wr_sel_r)
            data_r <= seq_rdata;
        else if (wr_data && !single_r)
            data_r <= data_wv;
    end

    // Access sequencer
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_r <= efa_pkg::ST_IDLE;
            kick_r <= 1'b0;
            idx_r <= 5'h00;
            sum_r <= 32'h0000_0000;
        end
        else
        begin
            kick_r <= 1'b0;
            unique case (state_r)
                efa_pkg::ST_IDLE:
                begin
                    idx_r <= 5'h00;
                    sum_r <= 32'h0000_0000;
                    if (reload_start || single_start)
                    begin
                        state_r <= reload_start ? efa_pkg::ST_RELOAD : efa_pkg::ST_SINGLE;
                        kick_r <= 1'b1;
                    end
                end
                efa_pkg::ST_RELOAD:
                    if (seq_done)
                    begin
                        if (last_dword)
                            state_r <= efa_pkg::ST_IDLE;
                        else
                        begin
                            sum_r <= sum_r + seq_rdata;
                            idx_r <= idx_r + 5'h01;
                            kick_r <= 1'b1;
                        end
                    end
                efa_pkg::ST_SINGLE:
                    if (seq_done)
                        state_r <= efa_pkg::ST_IDLE;
                default:
                    state_r <= efa_pkg::ST_IDLE;
            endcase
        end
    end

    efa_pair_seq u_seq (
        .aclk(aclk),
        .aresetn(aresetn),
        .start(kick_r),
        .write(seq_write),
        .dword_off(seq_off),
        .wdata(data_r),
        .done(seq_done),
        .rdata(seq_rdata),
        .word_req(word_req),
        .word_we(word_we),
        .word_addr(word_addr),
        .word_wdata(word_wdata),
        .word_ack(word_ack),
        .word_rdata(word_rdata)
    );

    efa_img_mem u_img (
        .aclk(aclk),
        .aresetn(aresetn),
        .we(img_we),
        .waddr(idx_r[3:0]),
        .wdata(seq_rdata),
        .raddr(csr_img_index),
        .rdata(csr_img_value)
    );

    // Checks
    reload_busy_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (state_r == efa_pkg::ST_RELOAD) |-> multi_r)
        else $error("Multiple-access bit dropped during reload");
    reload_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (chk_end && !soft_reset) |=> !multi_r && state_r == efa_pkg::ST_IDLE)
        else $error("Multiple-access bit not cleared after reload");
    multi_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (cmd_wr && c_multi && c_wr) |=> cmd_err_r && !single_r && state_r == efa_pkg::ST_IDLE)
        else $error("Multi-word write was not refused");
    reset_reload_a: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(aresetn) |-> multi_r && rd_sel_r && !wr_sel_r)
        else $error("Reload not armed after reset");
    single_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (single_done && !wr_sel_r) |=> data_r == $past(seq_rdata) && !single_r)
        else $error("Single read data not captured");
    single_busy_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (state_r == efa_pkg::ST_SINGLE) |-> single_r)
        else $error("Single-access bit dropped during access");
    flash_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (wr_ctrl && w_strb_r[2]) |=> gate_r == $past(w_data_r[efa_pkg::GATE_BIT]))
        else $error("Flash write gate not taken from control write");
    sum_check_a: assert property (@(posedge aclk) disable iff (!aresetn)
        chk_fail |=> sum_err_r)
        else $error("Checksum error not flagged");
    reserved_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (rd_fire && rd_ctrl) |=> rdata[31:22] == 10'h000 && rdata[15:13] == 3'h0 && !rdata[7])
        else $error("Reserved control bits read nonzero");
    busy_ignore_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (wr_ctrl && cmd_lock && !soft_reset) |=> $stable(addr_r) && $stable(wr_sel_r))
        else $error("Command write taken while busy");
    reload_done_c: cover property (@(posedge aclk) disable iff (!aresetn) chk_end);
    reload_fail_c: cover property (@(posedge aclk) disable iff (!aresetn) chk_fail);
    single_rd_c: cover property (@(posedge aclk) disable iff (!aresetn) single_done && !wr_sel_r);
    single_wr_c: cover property (@(posedge aclk) disable iff (!aresetn) single_done && wr_sel_r);

endmodule : efa_eeprom_ctrl

// ==== core/efa_pkg.sv ====
// Constants and types shared by the EEPROM and flash access control block
package efa_pkg;

    // Register byte offsets on the AXI4-Lite bus
    localparam logic [7:0] CTRL_OFF = 8'h00;
    localparam logic [7:0] DATA_OFF = 8'h04;
    localparam logic [7:0] STAT_OFF = 8'h08;

    // Control register field positions, plus the status register error bit
    localparam int PRESENT_BIT = 0;
    localparam int RD_BIT = 1;
    localparam int WR_BIT = 2;
    localparam int SUMERR_BIT = 4;
    localparam int MULTI_BIT = 5;
    localparam int SINGLE_BIT = 6;
    localparam int ADDR_LO = 8;
    localparam int ADDR_HI = 12;
    localparam int TIM_LO = 16;
    localparam int TIM_HI = 19;
    localparam int FLASH_BIT = 20;
    localparam int GATE_BIT = 21;
    localparam int CMDERR_BIT = 0;

    // Values after reset
    localparam logic RD_RST = 1'b1;
    localparam logic WR_RST = 1'b0;
    localparam logic MULTI_RST = 1'b1;
    localparam logic SINGLE_RST = 1'b0;
    localparam logic GATE_RST = 1'b0;
    localparam logic [4:0] ADDR_RST = 5'h00;
    localparam logic [3:0] TIM_RST = 4'h0;
    localparam logic [31:0] DATA_RST = 32'h0000_0000;

    // Reload image: 16 dwords, then the stored checksum dword
    localparam int IMG_DEPTH = 16;
    localparam int IMG_AW = 4;
    localparam logic [4:0] SUM_IDX = 5'h10;

    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RELOAD = 2'b01,
        ST_SINGLE = 2'b10
    } efa_state_e;

    typedef enum logic [1:0] {
        SQ_IDLE = 2'b00,
        SQ_LO = 2'b01,
        SQ_HI = 2'b10
    } efa_seq_e;

endpackage : efa_pkg

// ==== core/efa_img_mem.sv ====
// Reloaded configuration image store with registered read data
`timescale 1ns/1ps
module efa_img_mem (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Write port
    input wire logic we,
    input wire logic [efa_pkg::IMG_AW-1:0] waddr,
    input wire logic [31:0] wdata,
    // Read port
    input wire logic [efa_pkg::IMG_AW-1:0] raddr,
    output logic [31:0] rdata
);

    logic [31:0] mem [efa_pkg::IMG_DEPTH];
    logic [31:0] rdata_r;

    always_ff @(posedge aclk)
    begin
        if (we)
        begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            rdata_r <= 32'h0000_0000;
        else
            rdata_r <= mem[raddr];
    end

    assign rdata = rdata_r;

endmodule : efa_img_mem

// ==== core/efa_pair_seq.sv ====
// Dword access split into two 16-bit word accesses, low word first
`timescale 1ns/1ps
module efa_pair_seq (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Dword request
    input wire logic start,
    input wire logic write,
    input wire logic [4:0] dword_off,
    input wire logic [31:0] wdata,
    output logic done,
    output logic [31:0] rdata,
    // Word port to the EEPROM interface
    output logic word_req,
    output logic word_we,
    output logic [5:0] word_addr,
    output logic [15:0] word_wdata,
    input wire logic word_ack,
    input wire logic [15:0] word_rdata
);

    efa_pkg::efa_seq_e state_r;
    logic [4:0] off_r;
    logic we_r;
    logic [31:0] wd_r;
    logic [31:0] rdata_r;
    logic done_r;
    wire is_hi = (state_r == efa_pkg::SQ_HI);

    // Dword n covers words 2n and 2n+1
    assign word_req = (state_r != efa_pkg::SQ_IDLE);
    assign word_addr = {off_r, is_hi};
    assign word_we = we_r;
    assign word_wdata = is_hi ? wd_r[31:16] : wd_r[15:0];
    assign done = done_r;
    assign rdata = rdata_r;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_r <= efa_pkg::SQ_IDLE;
            off_r <= 5'h00;
            we_r <= 1'b0;
            wd_r <= 32'h0000_0000;
            rdata_r <= 32'h0000_0000;
            done_r <= 1'b0;
        end
        else
        begin
            done_r <= 1'b0;
            unique case (state_r)
                efa_pkg::SQ_IDLE:
                    if (start)
                    begin
                        off_r <= dword_off;
                        we_r <= write;
                        wd_r <= wdata;
                        state_r <= efa_pkg::SQ_LO;
                    end
                efa_pkg::SQ_LO:
                    if (word_ack)
                    begin
                        rdata_r[15:0] <= word_rdata;
                        state_r <= efa_pkg::SQ_HI;
                    end
                efa_pkg::SQ_HI:
                    if (word_ack)
                    begin
                        rdata_r[31:16] <= word_rdata;
                        state_r <= efa_pkg::SQ_IDLE;
                        done_r <= 1'b1;
                    end
                default:
                    state_r <= efa_pkg::SQ_IDLE;
            endcase
        end
    end

    pair_order_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (word_ack && state_r == efa_pkg::SQ_LO) |=>
            word_req && word_addr[0] && word_addr[5:1] == $past(word_addr[5:1]))
        else $error("High word does not follow low word of the same dword");

endmodule : efa_pair_seq

// ==== verif/efa_nv_model.sv ====
// Word-wide EEPROM model answering the word port
`timescale 1ns/1ps
module efa_nv_model (
    // Clock
    input wire logic aclk,
    // Word port
    input wire logic word_req,
    input wire logic word_we,
    input wire logic [5:0] word_addr,
    input wire logic [15:0] word_wdata,
    output logic word_ack,
    output logic [15:0] word_rdata
);
    logic [15:0] mem [64];
    logic [2:0] wait_r;
    initial
    begin
        word_ack = 1'b0;
        word_rdata = 16'h5a5a;
        wait_r = 3'h2;
    end
    // Answers after a random wait; read data toggles outside an answer
    always @(posedge aclk)
    begin
        word_ack <= 1'b0;
        word_rdata <= ~word_rdata;
        if (word_req && wait_r == 3'h0)
        begin
            word_ack <= 1'b1;
            word_rdata <= mem[word_addr];
            if (word_we)
                mem[word_addr] <= word_wdata;
            wait_r <= 3'($urandom % 6 + 1);
        end
        else if (word_req)
            wait_r <= wait_r - 3'h1;
    end
endmodule : efa_nv_model

// ==== verif/efa_eeprom_ctrl_bench.sv ====
// Self-checking bench for the EEPROM and flash access control block
`timescale 1ns/1ps
module efa_eeprom_ctrl_bench;
    logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0, soft_reset = 1'b0, flash_attached = 1'b0;
    logic rom_wr_req = 1'b0, nv_device_present = 1'b1;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, csr_img_value, rv, d;
    logic [3:0] wstrb = 4'hf, csr_img_index = 4'h0, rom_timing, t;
    logic [1:0] bresp, rresp, r, wr_resp;
    logic awready, wready, bvalid, arready, rvalid, word_req, word_we, word_ack;
    logic flash_wr_strobe;
    logic [5:0] word_addr;
    logic [15:0] word_wdata, word_rdata;
    logic [4:0] n;
    int error_cnt = 0, total_checks = 0;

    efa_eeprom_ctrl i_efa_eeprom_ctrl (
        .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
        .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
        .rready, .soft_reset, .nv_device_present, .flash_attached, .word_req,
        .word_we, .word_addr, .word_wdata, .word_ack, .word_rdata, .csr_img_index,
        .csr_img_value, .rom_wr_req, .flash_wr_strobe, .rom_timing
    );
    efa_nv_model i_efa_nv_model (
        .aclk, .word_req, .word_we, .word_addr, .word_wdata, .word_ack, .word_rdata
    );

    initial
        forever #10 aclk = ~aclk;

    task automatic stop_test();
        $display("checks=%0d errors=%0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : stop_test

    initial
    begin
        #400000;
        error_cnt++;
        stop_test();
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic axw(input logic [7:0] a, input logic [31:0] v);
        logic ak, wk, bk;
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(negedge aclk);
            ak = awready;
            wk = wready;
            bk = bvalid;
            wr_resp = bresp;
            @(posedge aclk);
            if (ak)
                awvalid <= 1'b0;
            if (wk)
                wvalid <= 1'b0;
        end
        while (!bk);
        bready <= 1'b0;
        @(posedge aclk);
    endtask : axw

    task automatic axr(input logic [7:0] a, output logic [31:0] v, output logic [1:0] s);
        logic ak, rk;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(negedge aclk);
            ak = arready;
            rk = rvalid;
            v = rdata;
            s = rresp;
            @(posedge aclk);
            if (ak)
                arvalid <= 1'b0;
        end
        while (!rk);
        rready <= 1'b0;
        @(posedge aclk);
    endtask : axr

    task automatic poll(input int b);
        do
            axr(efa_pkg::CTRL_OFF, rv, r);
        while (rv[b] !== 1'b0);
    endtask : poll

    function automatic logic [31:0] dw(input int i);
        return {i_efa_nv_model.mem[2*i+1], i_efa_nv_model.mem[2*i]};
    endfunction : dw

    task automatic fix_sum();
        logic [31:0] s;
        s = 32'h0;
        for (int i = 0; i < 16; i++)
            s += dw(i);
        i_efa_nv_model.mem[32] = s[15:0];
        i_efa_nv_model.mem[33] = s[31:16];
    endtask : fix_sum

    task automatic img(input logic [3:0] i, input logic [31:0] e);
        csr_img_index <= i;
        @(posedge aclk);
        @(negedge aclk);
        chk(csr_img_value, e);
        @(posedge aclk);
    endtask : img

    initial
    begin
        void'($urandom(32'hb119));
        for (int i = 0; i < 64; i++)
            i_efa_nv_model.mem[i] = 16'($urandom);
        fix_sum();
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        poll(efa_pkg::MULTI_BIT);
        chk(rv, 32'h0000_0003);
        for (int i = 0; i < 16; i++)
            img(4'(i), dw(i));
        repeat (4)
        begin
            n = 5'($urandom % 16);
            d = $urandom;
            axw(efa_pkg::DATA_OFF, d);
            axw(efa_pkg::CTRL_OFF, {19'h0, n, 8'h44});
            poll(efa_pkg::SINGLE_BIT);
            chk(dw(n), d);
            axw(efa_pkg::DATA_OFF, ~d);
            axw(efa_pkg::CTRL_OFF, {19'h0, n, 8'h42});
            axw(efa_pkg::CTRL_OFF, 32'h0000_1f22);
            poll(efa_pkg::SINGLE_BIT);
            chk({27'h0, rv[12:8]} | (rv & 32'h20), {27'h0, n});
            axr(efa_pkg::DATA_OFF, rv, r);
            chk(rv, d);
        end
        axw(efa_pkg::CTRL_OFF, 32'h0000_0024);
        axr(efa_pkg::STAT_OFF, rv, r);
        chk(rv, 32'h0000_0001);
        axr(efa_pkg::CTRL_OFF, rv, r);
        chk(rv & 32'h60, 32'h0);
        axw(efa_pkg::CTRL_OFF, 32'h0000_0022);
        poll(efa_pkg::MULTI_BIT);
        chk(rv & 32'h10, 32'h10);
        fix_sum();
        soft_reset <= 1'b1;
        @(posedge aclk);
        soft_reset <= 1'b0;
        repeat (2) @(posedge aclk);
        poll(efa_pkg::MULTI_BIT);
        chk(rv & 32'h10, 32'h0);
        img(n[3:0], d);
        t = 4'($urandom);
        flash_attached <= 1'b1;
        rom_wr_req <= 1'b1;
        axw(efa_pkg::CTRL_OFF, {12'hffe, t, 16'he080});
        axr(efa_pkg::CTRL_OFF, rv, r);
        chk(rv, {12'h003, t, 16'h0001});
        @(negedge aclk);
        chk(32'(rom_timing), 32'(t));
        chk(32'(flash_wr_strobe), 32'h1);
        @(posedge aclk);
        axw(efa_pkg::CTRL_OFF, 32'h0);
        @(negedge aclk);
        chk(32'(flash_wr_strobe), 32'h0);
        @(posedge aclk);
        flash_attached <= 1'b0;
        rom_wr_req <= 1'b0;
        axr(efa_pkg::CTRL_OFF, rv, r);
        chk(rv, 32'h0000_0001);
        axr(8'h0c, rv, r);
        chk(32'(r), 32'h2);
        chk(rv, 32'h0);
        axw(8'h0c, 32'hffff_ffff);
        chk(32'(wr_resp), 32'h2);
        axw(efa_pkg::STAT_OFF, 32'h1);
        chk(32'(wr_resp), 32'h0);
        axr(efa_pkg::STAT_OFF, rv, r);
        chk(rv, 32'h0);
        axw(efa_pkg::CTRL_OFF, 32'h0000_0046);
        axr(efa_pkg::STAT_OFF, rv, r);
        chk(rv, 32'h1);
        nv_device_present <= 1'b0;
        axw(efa_pkg::CTRL_OFF, {19'h0, n, 8'h42});
        poll(efa_pkg::SINGLE_BIT);
        chk(rv, {19'h0, n, 8'h02});
        axr(efa_pkg::DATA_OFF, rv, r);
        chk(rv, d);
        stop_test();
    end
endmodule : efa_eeprom_ctrl_bench
